// >>> design/hrc_defines.vh
// constants for the host port reset sequencer with erratic chirp handling
`ifndef HRC_DEFINES_VH
`define HRC_DEFINES_VH

// =====================================================================
// register map (word index on the plain register port)
`define HRC_ADDR_W          4
`define HRC_REG_CTRL_A      4'h0
`define HRC_REG_CTRL_B      4'h1
`define HRC_REG_PHY         4'h2
`define HRC_REG_FLAGS       4'h3
`define HRC_REG_MASK        4'h4
`define HRC_REG_STATE       4'h5

// =====================================================================
// control field layout
`define HRC_REQ_LSB         0
`define HRC_REQ_MSB         2
`define HRC_ABORT_BIT       7
`define HRC_INHIBIT_BIT     0

// transition request codes
`define HRC_REQ_NONE        3'h0
`define HRC_REQ_RESET       3'h2
`define HRC_REQ_DISABLE     3'h3
`define HRC_REQ_RUN         3'h4

// host state monitor codes
`define HRC_HS_IDLE         3'h0
`define HRC_HS_RESET        3'h2
`define HRC_HS_DISABLED     3'h3
`define HRC_HS_RUN          3'h4

// flag bit positions
`define HRC_FLAG_BAD        0
`define HRC_FLAG_GOOD       1
`define HRC_FLAG_DONE       2
`define HRC_FLAG_W          3

// line condition codes
`define HRC_LINE_SE0        2'h0
`define HRC_LINE_J          2'h1

// phy operation mode codes
`define HRC_PHY_OPERATION_MODE_NORMAL   2'h0
`define HRC_PHY_OPERATION_MODE_CHIRP    2'h2

// =====================================================================
// timing, clock 250 MHz
`define HRC_CLK_MHZ         250
`define HRC_T_CHIRP_J_NS    2500
`define HRC_T_BAD_US        7000
`define HRC_T_RST_US        50000
`define HRC_T_WAIT_K_US     50
`define HRC_T_BIT_US        50
`define HRC_T_DONE_US       100
`define HRC_T_SOF_US        125
`define HRC_ABORT_CYC       6
`define HRC_SLOW_CLK_MHZ    60

`endif

// >>> design/hrc_reset_chirp.v
// host port reset sequencer with erratic peer chirp handling
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "hrc_defines.vh"

// Notes on behaviour
// - inhibit 0 and chirp error: no host chirp for the rest of reset.
// - reset request sets state RESET, HS phy, normal mode, detection on.
// - peer chirp counts only after unbroken J line for 2.5 us.
// - chirp not ended 7 ms after request: bad flag, detection off.
// - inhibit 0: reset done raised 50 ms after the bad flag.
// - inhibit 1: on SE0 after error set HS speed and good flag.
// - inhibit 1: host chirp K starts within 100 us of chirp end.
// - host alternates chirp K and J, each held 40 to 60 us.
// - host chirp lasts over 50 ms from first K, then ends.
// - reset done raised within 150 us after host chirp ends.
// - run request within 200 us; first SOF 120 to 130 us later.
// - abort value stops sequence; abort bit self-clears after six slow cycles.
module hrc_reset_chirp #(
    parameter T_BAD_CYC  = (`HRC_T_BAD_US * `HRC_CLK_MHZ),
    parameter T_RST_CYC  = (`HRC_T_RST_US * `HRC_CLK_MHZ) + 1,
    parameter T_BIT_CYC  = (`HRC_T_BIT_US * `HRC_CLK_MHZ),
    parameter T_WAIT_CYC = (`HRC_T_WAIT_K_US * `HRC_CLK_MHZ),
    parameter T_DONE_CYC = (`HRC_T_DONE_US * `HRC_CLK_MHZ),
    parameter T_SOF_CYC  = (`HRC_T_SOF_US * `HRC_CLK_MHZ),
    // unbroken J run, rounded up to whole cycles
    parameter T_J_CYC    = (`HRC_T_CHIRP_J_NS * `HRC_CLK_MHZ + 999) / 1000
) (
    // clock, reset, enable
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        clk_en,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // transceiver control
    input  wire [1:0]  line_condition,
    output reg         transceiver_speed_select,
    output reg         termination_select,
    output reg  [1:0]  phy_operation_mode,
    output reg         chirp_drive_k,
    output reg         chirp_drive_j,
    output reg         chirp_detect_on,
    output reg         port_speed_hs,
    output reg         sof_start,
    // interrupt
    output wire        irq
);

    // =================================================================
    // constants
    localparam CNT_W     = 24;
    localparam ABORT_CYC = (`HRC_ABORT_CYC * `HRC_CLK_MHZ + `HRC_SLOW_CLK_MHZ - 1)
                           / `HRC_SLOW_CLK_MHZ;

    localparam ST_IDLE   = 7'h01;
    localparam ST_DETECT = 7'h02;
    localparam ST_WAITSE = 7'h04;
    localparam ST_WAITK  = 7'h08;
    localparam ST_CHIRP  = 7'h10;
    localparam ST_FINISH = 7'h20;
    localparam ST_HOLD   = 7'h40;

    function [CNT_W-1:0] cyc;
        input integer n;
        begin
            cyc = n[CNT_W-1:0];
        end
    endfunction

    // =================================================================
    // registers
    reg [6:0]              state;
    reg [2:0]              req_field;
    reg                    transition_abort;
    reg                    chirp_finish_inhibit;
    reg [2:0]              host_state_monitor;
    reg [`HRC_FLAG_W-1:0]  flags;
    reg [`HRC_FLAG_W-1:0]  mask;
    reg [CNT_W-1:0]        t_main;
    reg [CNT_W-1:0]        t_step;
    reg [CNT_W-1:0]        t_aux;
    // wide enough for the whole abort hold at the fast clock
    reg [4:0]              abort_cnt;
    reg                    chirp_seen;
    reg                    sof_pending;
    reg [`HRC_FLAG_W-1:0]  flag_set;

    wire wr_ctrl_a = reg_wr && (reg_addr == `HRC_REG_CTRL_A);
    wire [2:0] wr_req = reg_wdata[`HRC_REQ_MSB:`HRC_REQ_LSB];
    wire abort_req = wr_ctrl_a && reg_wdata[`HRC_ABORT_BIT] && (wr_req == `HRC_REQ_NONE);

    assign irq = |(flags & mask);

    // =================================================================
    // sequencer
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state                    <= ST_IDLE;
            req_field                <= `HRC_REQ_NONE;
            transition_abort         <= 1'b0;
            host_state_monitor       <= `HRC_HS_IDLE;
            transceiver_speed_select <= 1'b0;
            termination_select       <= 1'b0;
            phy_operation_mode       <= `HRC_PHY_OPERATION_MODE_NORMAL;
            chirp_drive_k            <= 1'b0;
            chirp_drive_j            <= 1'b0;
            chirp_detect_on          <= 1'b0;
            port_speed_hs            <= 1'b0;
            sof_start                <= 1'b0;
            sof_pending              <= 1'b0;
            t_main                   <= {CNT_W{1'b0}};
            t_step                   <= {CNT_W{1'b0}};
            t_aux                    <= {CNT_W{1'b0}};
            abort_cnt                <= 5'h00;
            chirp_seen               <= 1'b0;
            flag_set                 <= {`HRC_FLAG_W{1'b0}};
        end else if (clk_en) begin
            flag_set  <= {`HRC_FLAG_W{1'b0}};
            sof_start <= 1'b0;
            t_main    <= t_main + 1'b1;
            t_step    <= t_step + 1'b1;
            // abort bit self-clear after stop processing
            if (transition_abort) begin
                if (abort_cnt == ABORT_CYC[4:0] - 5'h01) begin
                    transition_abort <= 1'b0;
                end
                abort_cnt <= abort_cnt + 5'h01;
            end
            // first SOF after run request
            if (sof_pending) begin
                if (t_aux == cyc(T_SOF_CYC)) begin
                    sof_start   <= 1'b1;
                    sof_pending <= 1'b0;
                end
                t_aux <= t_aux + 1'b1;
            end
            if (abort_req) begin
                // abort wins over any running step; port left idle
                transition_abort <= 1'b1;
                abort_cnt        <= 5'h00;
                req_field        <= `HRC_REQ_NONE;
                host_state_monitor <= `HRC_HS_IDLE;
                state            <= ST_IDLE;
                chirp_drive_k    <= 1'b0;
                chirp_drive_j    <= 1'b0;
                chirp_detect_on  <= 1'b0;
                phy_operation_mode <= `HRC_PHY_OPERATION_MODE_NORMAL;
                sof_pending      <= 1'b0;
            end else if (wr_ctrl_a && !transition_abort) begin
                req_field <= wr_req;
                if (wr_req == `HRC_REQ_RESET) begin
                    host_state_monitor       <= `HRC_HS_RESET;
                    transceiver_speed_select <= 1'b1;
                    termination_select       <= 1'b1;
                    phy_operation_mode       <= `HRC_PHY_OPERATION_MODE_NORMAL;
                    chirp_detect_on          <= 1'b1;
                    port_speed_hs            <= 1'b0;
                    chirp_seen               <= 1'b0;
                    // a stale run request must not fire mid-reset
                    sof_pending              <= 1'b0;
                    t_main                   <= {CNT_W{1'b0}};
                    t_aux                    <= {CNT_W{1'b0}};
                    state                    <= ST_DETECT;
                end else if (wr_req == `HRC_REQ_RUN && state == ST_IDLE) begin
                    host_state_monitor <= `HRC_HS_RUN;
                    phy_operation_mode <= `HRC_PHY_OPERATION_MODE_NORMAL;
                    t_aux              <= {CNT_W{1'b0}};
                    sof_pending        <= 1'b1;
                end else if (wr_req == `HRC_REQ_DISABLE && state == ST_IDLE) begin
                    host_state_monitor <= `HRC_HS_DISABLED;
                end
            end else begin
                case (state)
                    ST_IDLE: begin
                    end
                    ST_DETECT: begin
                        // unbroken J run qualifies the peer chirp
                        if (line_condition == `HRC_LINE_J) begin
                            if (t_aux == cyc(T_J_CYC) - 1'b1) begin
                                chirp_seen <= 1'b1;
                            end else if (t_aux < cyc(T_J_CYC)) begin
                                t_aux <= t_aux + 1'b1;
                            end
                        end else begin
                            t_aux <= {CNT_W{1'b0}};
                        end
                        if (t_main >= cyc(T_BAD_CYC)) begin
                            flag_set[`HRC_FLAG_BAD] <= 1'b1;
                            chirp_detect_on <= 1'b0;
                            t_step <= {CNT_W{1'b0}};
                            if (chirp_finish_inhibit) begin
                                state <= ST_WAITSE;
                            end else begin
                                state <= ST_HOLD;
                            end
                        end
                    end
                    ST_WAITSE: begin
                        // first SE0 after the error marks the peer chirp end
                        if (line_condition == `HRC_LINE_SE0) begin
                            port_speed_hs <= 1'b1;
                            flag_set[`HRC_FLAG_GOOD] <= 1'b1;
                            t_step <= {CNT_W{1'b0}};
                            state  <= ST_WAITK;
                        end
                    end
                    ST_WAITK: begin
                        if (t_step >= cyc(T_WAIT_CYC)) begin
                            phy_operation_mode <= `HRC_PHY_OPERATION_MODE_CHIRP;
                            chirp_drive_k <= 1'b1;
                            t_step <= {CNT_W{1'b0}};
                            t_main <= {CNT_W{1'b0}};
                            state  <= ST_CHIRP;
                        end
                    end
                    ST_CHIRP: begin
                        // end only on a bit boundary, so the last bit is never cut short
                        if (t_main >= cyc(T_RST_CYC) && t_step >= cyc(T_BIT_CYC)) begin
                            chirp_drive_k <= 1'b0;
                            chirp_drive_j <= 1'b0;
                            phy_operation_mode <= `HRC_PHY_OPERATION_MODE_NORMAL;
                            t_step <= {CNT_W{1'b0}};
                            state  <= ST_FINISH;
                        end else if (t_step >= cyc(T_BIT_CYC)) begin
                            chirp_drive_k <= ~chirp_drive_k;
                            chirp_drive_j <= ~chirp_drive_j;
                            t_step <= {CNT_W{1'b0}};
                        end
                    end
                    ST_FINISH: begin
                        if (t_step >= cyc(T_DONE_CYC)) begin
                            flag_set[`HRC_FLAG_DONE] <= 1'b1;
                            req_field <= `HRC_REQ_NONE;
                            state     <= ST_IDLE;
                        end
                    end
                    ST_HOLD: begin
                        // bus reset held with no host chirp
                        if (t_step >= cyc(T_RST_CYC)) begin
                            flag_set[`HRC_FLAG_DONE] <= 1'b1;
                            req_field <= `HRC_REQ_NONE;
                            state     <= ST_IDLE;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // =================================================================
    // software registers, flags and read port
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            chirp_finish_inhibit <= 1'b0;
            mask                 <= {`HRC_FLAG_W{1'b0}};
            flags                <= {`HRC_FLAG_W{1'b0}};
            reg_rdata            <= 8'h00;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `HRC_REG_CTRL_B) begin
                chirp_finish_inhibit <= reg_wdata[`HRC_INHIBIT_BIT];
            end
            if (reg_wr && reg_addr == `HRC_REG_MASK) begin
                mask <= reg_wdata[`HRC_FLAG_W-1:0];
            end
            // a new event wins over a write-one clear
            if (reg_wr && reg_addr == `HRC_REG_FLAGS) begin
                flags <= (flags & ~reg_wdata[`HRC_FLAG_W-1:0]) | flag_set;
            end else begin
                flags <= flags | flag_set;
            end
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    // state monitor in the spare middle bits of the control word
                    `HRC_REG_CTRL_A: reg_rdata <= {transition_abort, host_state_monitor,
                                                   1'b0, req_field};
                    `HRC_REG_CTRL_B: reg_rdata <= {7'h00, chirp_finish_inhibit};
                    `HRC_REG_PHY:    reg_rdata <= {chirp_detect_on, port_speed_hs,
                                                   chirp_drive_j, chirp_drive_k,
                                                   phy_operation_mode,
                                                   termination_select,
                                                   transceiver_speed_select};
                    `HRC_REG_FLAGS:  reg_rdata <= {5'h00, flags};
                    `HRC_REG_MASK:   reg_rdata <= {5'h00, mask};
                    `HRC_REG_STATE:  reg_rdata <= {chirp_seen, state};
                    default:         reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // hrc_reset_chirp

// >>> tb/hrc_peer_model.sv
// downstream peer model driving the line condition
`timescale 1ns/1ps
module hrc_peer_model (
    // clock and reset
    input wire        sys_clk,
    input wire        rst_b,
    // host side
    input wire        chirp_detect_on,
    input wire        chirp_drive_k,
    input wire  [7:0] start_dly,
    input wire        chirp_end,
    // bus side
    output logic [1:0] line_condition,
    output logic       peer_hs
);
    logic [7:0] cnt;
    logic       armed;
    // ==========================================================
    // chirp j that only ends on command, to force the error path
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt            <= 8'h00;
            armed          <= 1'b0;
            line_condition <= 2'h0;
            peer_hs        <= 1'b0;
        end else begin
            if (chirp_detect_on && !armed) begin
                armed   <= 1'b1;
                cnt     <= 8'h00;
                peer_hs <= 1'b0;
            end else if (armed && cnt != start_dly)
                cnt <= cnt + 8'h01;
            else if (armed)
                line_condition <= 2'h1;
            if (chirp_end) begin
                armed          <= 1'b0;
                line_condition <= 2'h0;
            end
            if (chirp_drive_k)
                peer_hs <= 1'b1;
        end
    end
endmodule // hrc_peer_model

// >>> tb/hrc_reset_chirp_monitor.sv
// checker for the host port reset sequencer
`timescale 1ns/1ps
module hrc_reset_chirp_monitor #(
    parameter T_BAD_CYC  = 200,
    parameter T_RST_CYC  = 400,
    parameter T_BIT_CYC  = 20,
    parameter T_WAIT_CYC = 10,
    parameter T_SOF_CYC  = 30
) (
    // clock, reset, enable
    input wire       sys_clk,
    input wire       rst_b,
    input wire       clk_en,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // transceiver side
    input wire [1:0] line_condition,
    input wire       transceiver_speed_select,
    input wire       termination_select,
    input wire [1:0] phy_operation_mode,
    input wire       chirp_drive_k,
    input wire       chirp_drive_j,
    input wire       chirp_detect_on,
    input wire       port_speed_hs,
    input wire       sof_start,
    input wire       irq
);
    localparam int WAIT_HI = T_WAIT_CYC + 3;
    localparam int SOF_LO  = T_SOF_CYC;
    localparam int SOF_HI  = T_SOF_CYC + 2;
    integer        k_run;
    integer        det_run;
    integer        ch_run;
    // ==========================================================
    // run lengths, too long for a repetition operator
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            k_run   <= 0;
            det_run <= 0;
            ch_run  <= 0;
        end else begin
            k_run   <= chirp_drive_k ? k_run + 1 : 0;
            det_run <= chirp_detect_on ? det_run + 1 : 0;
            ch_run  <= (chirp_drive_k | chirp_drive_j) ? ch_run + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // properties
    property p_start;
        reg_wr && reg_addr == 4'h0 && reg_wdata == 8'h02 |=> chirp_detect_on
            && transceiver_speed_select && termination_select && phy_operation_mode == 2'h0;
    endproperty
    a_start: assert property (p_start) else $error("reset setup missing");
    property p_bad_tmo; det_run <= T_BAD_CYC + 2; endproperty
    a_bad_tmo: assert property (p_bad_tmo) else $error("detect held too long");
    property p_kwait; $rose(port_speed_hs) |-> ##[1:WAIT_HI] chirp_drive_k; endproperty
    a_kwait: assert property (p_kwait) else $error("chirp k late");
    property p_kj_excl; !(chirp_drive_k && chirp_drive_j); endproperty
    a_kj_excl: assert property (p_kj_excl) else $error("k and j together");
    property p_bit_len;
        $fell(chirp_drive_k) && chirp_drive_j |-> k_run >= T_BIT_CYC - 1 && k_run <= T_BIT_CYC + 1;
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("chirp bit length off");
    property p_chirp_len; ch_run <= T_RST_CYC + 2 * T_BIT_CYC + 2; endproperty
    a_chirp_len: assert property (p_chirp_len) else $error("host chirp too long");
    property p_sof;
        reg_wr && reg_addr == 4'h0 && reg_wdata == 8'h04 |-> ##[SOF_LO:SOF_HI] sof_start;
    endproperty
    a_sof: assert property (p_sof) else $error("first sof not in window");
    property p_abort;
        reg_wr && reg_addr == 4'h0 && reg_wdata == 8'h80 |=>
            !chirp_drive_k && !chirp_drive_j && !chirp_detect_on;
    endproperty
    a_abort: assert property (p_abort) else $error("abort left port busy");
endmodule // hrc_reset_chirp_monitor

bind hrc_reset_chirp hrc_reset_chirp_monitor #(.T_BAD_CYC(T_BAD_CYC), .T_RST_CYC(T_RST_CYC),
    .T_BIT_CYC(T_BIT_CYC), .T_WAIT_CYC(T_WAIT_CYC), .T_SOF_CYC(T_SOF_CYC)) u_mon (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .line_condition(line_condition), .transceiver_speed_select(transceiver_speed_select),
    .termination_select(termination_select), .phy_operation_mode(phy_operation_mode),
    .chirp_drive_k(chirp_drive_k), .chirp_drive_j(chirp_drive_j),
    .chirp_detect_on(chirp_detect_on), .port_speed_hs(port_speed_hs),
    .sof_start(sof_start), .irq(irq));

// >>> tb/test_usb_host_reset_chirp_error.sv
// bench for the host port reset sequencer
`timescale 1ns/1ps
module test_usb_host_reset_chirp_error;
    localparam T_BAD = 200, T_RST = 400, T_BIT = 20, T_WAIT = 10, T_DONE = 10, T_SOF = 30;
    localparam T_J = 20;
    logic       sys_clk, rst_b, reg_wr, reg_rd, chirp_end;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, start_dly, rd_val;
    wire  [7:0] reg_rdata;
    wire  [1:0] line_condition, phy_mode;
    wire        tsel, term, ck, cj, det, hs, sof, irq, peer_hs;
    integer     seed, t0, t1, n, i;
    integer     n_fail = 0, n_checks = 0, cyc = 0, ch_cyc = 0;
    hrc_reset_chirp #(.T_BAD_CYC(T_BAD), .T_RST_CYC(T_RST), .T_BIT_CYC(T_BIT),
        .T_WAIT_CYC(T_WAIT), .T_DONE_CYC(T_DONE), .T_SOF_CYC(T_SOF), .T_J_CYC(T_J)) i_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .line_condition(line_condition), .transceiver_speed_select(tsel),
        .termination_select(term), .phy_operation_mode(phy_mode), .chirp_drive_k(ck),
        .chirp_drive_j(cj), .chirp_detect_on(det), .port_speed_hs(hs), .sof_start(sof),
        .irq(irq));
    hrc_peer_model i_peer (.sys_clk(sys_clk), .rst_b(rst_b), .chirp_detect_on(det),
        .chirp_drive_k(ck), .start_dly(start_dly), .chirp_end(chirp_end),
        .line_condition(line_condition), .peer_hs(peer_hs));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (ck | cj) ch_cyc <= ch_cyc + 1;
    end
    // ==========================================================
    // bus cycles, compare, waits
    task wr(input [3:0] a, input [7:0] d);
        @(posedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a);
        @(posedge sys_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function logic cond(input integer s);
        case (s)
            0: cond = irq;
            2: cond = ck;
            3: cond = !(ck | cj);
            default: cond = sof;
        endcase
    endfunction
    task wait_for(input integer s, input integer bound);
        n = 0;
        while (cond(s) !== 1'b1 && n < bound) begin
            @(posedge sys_clk) #1;
            n++;
        end
        if (n >= bound) begin
            n_fail++;
            $display("MISMATCH at %0t: wait %0d timed out", $time, s);
            final_report;
        end
    endtask
    task pulse_end;
        @(posedge sys_clk);
        chirp_end <= 1'b1;
        @(posedge sys_clk);
        chirp_end <= 1'b0;
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    initial begin
        seed = 88663;
        {rst_b, reg_wr, reg_rd, chirp_end, reg_addr, reg_wdata} = 16'h0000;
        start_dly = 8'h20;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(4'hf);
        chk(rd_val, 8'h00);
        // inhibit 0: error, long hold, host stays silent
        wr(4'h1, 8'h00);
        wr(4'h4, 8'h01);
        t0 = ch_cyc;
        wr(4'h0, 8'h02);
        t1 = cyc;
        rd(4'h0);
        chk(rd_val, 8'h22);
        chk({4'h0, tsel, term, phy_mode}, 8'h0c);
        wait_for(0, T_BAD + 20);
        chk({7'h0, cyc - t1 >= T_BAD - 1}, 8'h01);
        chk({7'h0, det}, 8'h00);
        t1 = cyc;
        wr(4'h3, 8'h01);
        wr(4'h4, 8'h04);
        rd(4'h3);
        chk(rd_val, 8'h00);
        rd(4'h5);
        chk({7'h0, rd_val[7]}, 8'h01);
        wait_for(0, T_RST + 40);
        chk({7'h0, cyc - t1 >= T_RST}, 8'h01);
        chk(8'(ch_cyc - t0), 8'h00);
        wr(4'h4, 8'h00);
        @(posedge sys_clk) #1;
        chk({7'h0, irq}, 8'h00);
        pulse_end;
        wr(4'h3, 8'h07);
        wr(4'h0, 8'h03);
        rd(4'h0);
        chk(rd_val, 8'h33);
        $display("test 1 silent reset after chirp error done");
        // inhibit 1: error, then peer ends and host chirps
        wr(4'h1, 8'h01);
        for (i = 0; i < 2; i++) begin
            start_dly <= 8'h10 + {1'b0, 7'($random(seed))};
            wr(4'h4, 8'h01);
            wr(4'h0, 8'h02);
            wait_for(0, T_BAD + 20);
            wr(4'h3, 8'h01);
            wr(4'h4, 8'h02);
            repeat (1 + ($random(seed) & 15)) @(posedge sys_clk);
            pulse_end;
            wait_for(0, 20);
            chk({7'h0, hs}, 8'h01);
            wr(4'h3, 8'h02);
            wr(4'h4, 8'h04);
            wait_for(2, T_WAIT);
            t0 = cyc;
            wait_for(3, T_RST + 3 * T_BIT);
            chk({7'h0, cyc - t0 >= T_RST}, 8'h01);
            chk({7'h0, peer_hs}, 8'h01);
            wait_for(0, T_DONE + 5);
            wr(4'h3, 8'h04);
            wr(4'h0, 8'h04);
            wait_for(4, T_SOF + 5);
            chk({7'h0, n >= T_SOF && n <= T_SOF + 2}, 8'h01);
        end
        $display("test 2 host chirp after chirp error done");
        // abort while the host chirps
        wr(4'h4, 8'h01);
        wr(4'h0, 8'h02);
        wait_for(0, T_BAD + 20);
        pulse_end;
        wait_for(2, T_WAIT + 10);
        wr(4'h0, 8'h80);
        t0 = cyc;
        rd(4'h0);
        t1 = ch_cyc;
        chk(rd_val, 8'h80);
        for (n = 0; n < 20 && rd_val[7] === 1'b1; n++) rd(4'h0);
        chk({7'h0, cyc - t0 >= 20 && cyc - t0 <= 32}, 8'h01);
        chk(8'(ch_cyc - t1), 8'h00);
        chk({7'h0, det}, 8'h00);
        wr(4'h0, 8'h03);
        rd(4'h0);
        chk(rd_val, 8'h33);
        $display("test 3 abort during host chirp done");
        final_report;
    end
endmodule // test_usb_host_reset_chirp_error
